// ---- src/crx_cfg.svh ----
// Register map, field positions and reset values of the receive ring block.
// Assumes inclusion by any file that decodes the APB map or ring fields.
`ifndef CRX_CFG_SVH
`define CRX_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses, one word each)
`define CRX_OFS_CTRL 8'h00
`define CRX_OFS_BASE 8'h04
`define CRX_OFS_SIZE 8'h08
`define CRX_OFS_WPTR 8'h0C
`define CRX_OFS_RPTR 8'h10
`define CRX_OFS_THR 8'h14
`define CRX_OFS_CARE 8'h18
`define CRX_OFS_MATCH 8'h1C
`define CRX_OFS_PIMSR 8'h20
`define CRX_OFS_PIMR 8'h24
`define CRX_OFS_PISR 8'h28
`define CRX_OFS_PIR 8'h2C
`define CRX_OFS_IMR 8'h30
`define CRX_OFS_PICR 8'h34

// ==========================================================================
// Field positions
`define CRX_CTRL_EN 0
`define CRX_CTRL_BUSY 1
`define CRX_CTRL_ABORT 2
`define CRX_BASE_LO 10
`define CRX_SIZE_HI 20
`define CRX_SIZE_LO 6
`define CRX_PTR_HI 19
`define CRX_PTR_LO 4
`define CRX_ID_HI 28
`define CRX_STD_LO 18
`define CRX_EXT_HI 17
`define CRX_EV_HI 16

// Event bits owned by the receive channel
`define CRX_EV_FILTERED 15
`define CRX_EV_RECV 9
`define CRX_EV_FILLED 7
`define CRX_EV_THRESH 5
`define CRX_EV_BUSFAULT 3
`define CRX_EV_OVERRUN 2
`define CRX_EV_RX_OWNED 17'h0_82AC

// ==========================================================================
// Reset values
`define CRX_CARE_RST 29'h1FFF_FFFF
`define CRX_ZERO_RST 32'h0000_0000
`define CRX_WORDS 4

`endif

// ---- src/crx_msg_mem.sv ----
// Four-word staging store for one received message.
// Assumes a whole message is written at once and read a word at a time.
`timescale 1ns/100ps

module crx_msg_mem
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [127:0] wr_msg,
	input wire logic [1:0] rd_idx,
	output logic [31:0] rd_data
);

	// ==================================================================
	// Storage
	logic [31:0] store [0:3];

	// Whole message written in one cycle, word 0 first in memory
	always_ff @(posedge pclk)
	begin
		if (wr_en)
		begin
			store[0] <= wr_msg[127:96];
			store[1] <= wr_msg[95:64];
			store[2] <= wr_msg[63:32];
			store[3] <= wr_msg[31:0];
		end
	end

	// Registered read port; a message being written shows through at once,
	// so the writer needs no extra cycle before its first word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= 32'h0000_0000;
		else if (wr_en)
			rd_data <= wr_msg[{~rd_idx, 5'h1F} -: 32];
		else
			rd_data <= store[rd_idx];
	end

endmodule

// ---- src/crx_pkg.sv ----
// Types shared by the receive ring block.
// Assumes nothing of its surroundings.
package crx_pkg;

	// ==================================================================
	// Ring writer states, one-hot
	typedef enum logic [2:0]
	{
		crx_idle = 3'b001,
		crx_load = 3'b010,
		crx_send = 3'b100
	} crx_state_t;

endpackage

// ---- src/crx_ring.sv ----
// Receive ring writer and event registers of a CAN controller.
// Assumes an APB master on pclk, a CAN engine that pulses finished messages
// and other events, and a one-word-at-a-time system bus master port.
//
// Summary of operation
// - Write pointer sits in bits 19-4, resets to zero, counts message slots.
// - Write pointer advances past each message stored without error.
// - One slot stays empty; storing stops before write reaches read.
// - Threshold in bits 19-4; reaching it raises the count event.
// - Accept when (id xor match) and care is zero; care resets ones.
// - Standard id is bits 28-18, extended id is bits 17-0.
// - Every source event sets its pending bit; core_event pulses on bits 15, 9, 7, 5, 3 and 2 are dropped.
// - Mask resets to zero; interrupt only for pending and unmasked bits.
// - Reading pending or pending-masked clears the pending bits.
// - Pending-masked reads pending ANDed with mask.
// - Pending-clear write clears only bits written as one.
// - Writing pending ORs data in; it never clears.
// - Pending-status reads pending without clearing.
// - Pending-masked-status reads pending ANDed with mask, no clearing.
// - Bits 16 down to 9: lost, filtered, fault counts, sync, sent, got.
// - Bits 8 down to 0: drained, filled, thresholds, bus faults, overrun.
// - All event register bits are zero after reset.
// - Bus fault raises its event regardless of abort; pointers stay valid.
// - Each message is four words; ring length counts groups of four.
// - Ring base comes from bits 31-10, aligned to 1024 bytes.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "crx_cfg.svh"

module crx_ring
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_msg_valid,
	input wire logic [31:0] rx_msg_w0,
	input wire logic [31:0] rx_msg_w1,
	input wire logic [31:0] rx_msg_w2,
	input wire logic [31:0] rx_msg_w3,
	input wire logic [16:0] core_event,
	output logic mem_valid,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic mem_error,
	output logic irq
);

	// ==================================================================
	// Helpers
	// Next ring slot; capacity is four messages per length unit
	function automatic logic [15:0] next_pos(input logic [15:0] ptr,
		input logic [14:0] len);
		logic [16:0] cap;
		logic [16:0] inc;
		cap = {len, 2'b00};
		inc = {1'b0, ptr} + 17'h0_0001;
		if (inc == cap)
			next_pos = 16'h0000;
		else
			next_pos = inc[15:0];
	endfunction

	// ==================================================================
	// State
	logic enable;
	logic abort;
	logic [21:0] base;
	logic [14:0] ring_len;
	logic [15:0] wptr;
	logic [15:0] rptr;
	logic [15:0] thr;
	logic [28:0] care;
	logic [28:0] match;
	logic [16:0] pend;
	logic [16:0] mask;
	logic [16:0] snap;
	logic [16:0] rx_ev;
	logic [16:0] next_pend;
	logic [1:0] word;
	crx_pkg::crx_state_t state;
	logic [31:0] rd_word;
	logic [28:0] rx_id;
	logic accept_id;
	logic ring_full;
	logic take;
	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic rd_clear;
	logic [15:0] new_wptr;

	// ==================================================================
	// APB decode
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;

	// Map check for error answer
	always_comb
	begin
		unique case (paddr)
			`CRX_OFS_CTRL, `CRX_OFS_BASE, `CRX_OFS_SIZE, `CRX_OFS_WPTR,
			`CRX_OFS_RPTR, `CRX_OFS_THR, `CRX_OFS_CARE, `CRX_OFS_MATCH,
			`CRX_OFS_PIMSR, `CRX_OFS_PIMR, `CRX_OFS_PISR, `CRX_OFS_PIR,
			`CRX_OFS_IMR, `CRX_OFS_PICR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~mapped;

	// Read data latched in the setup cycle, so it is stable in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= `CRX_ZERO_RST;
		else if (setup & ~pwrite)
		begin
			prdata <= `CRX_ZERO_RST;
			unique case (paddr)
				`CRX_OFS_CTRL: prdata <= {29'h0000_0000, abort,
					state != crx_pkg::crx_idle, enable};
				`CRX_OFS_BASE: prdata <= {base, 10'h000};
				`CRX_OFS_SIZE: prdata <= {11'h000, ring_len, 6'h00};
				`CRX_OFS_WPTR: prdata <= {12'h000, wptr, 4'h0};
				`CRX_OFS_RPTR: prdata <= {12'h000, rptr, 4'h0};
				`CRX_OFS_THR: prdata <= {12'h000, thr, 4'h0};
				`CRX_OFS_CARE: prdata <= {3'h0, care};
				`CRX_OFS_MATCH: prdata <= {3'h0, match};
				`CRX_OFS_PIMSR,
				`CRX_OFS_PIMR: prdata <= {15'h0000, pend & mask};
				`CRX_OFS_PISR,
				`CRX_OFS_PIR: prdata <= {15'h0000, pend};
				`CRX_OFS_IMR: prdata <= {15'h0000, mask};
				default: prdata <= `CRX_ZERO_RST;
			endcase
		end
	end

	// ==================================================================
	// Channel settings
	// Abort-on-fault clears enable after a bus fault; hardware wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable <= 1'b0;
			abort <= 1'b0;
		end
		else
		begin
			if (wr_acc && paddr == `CRX_OFS_CTRL)
			begin
				enable <= pwdata[`CRX_CTRL_EN];
				abort <= pwdata[`CRX_CTRL_ABORT];
			end
			if (state == crx_pkg::crx_send && mem_ready && mem_error && abort)
				enable <= 1'b0;
		end
	end

	// Ring geometry and filter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			base <= 22'h00_0000;
			ring_len <= 15'h0000;
			rptr <= 16'h0000;
			thr <= 16'h0000;
			care <= `CRX_CARE_RST;
			match <= 29'h0000_0000;
		end
		else if (wr_acc)
		begin
			unique case (paddr)
				`CRX_OFS_BASE: base <= pwdata[31:`CRX_BASE_LO];
				`CRX_OFS_SIZE:
					ring_len <= pwdata[`CRX_SIZE_HI:`CRX_SIZE_LO];
				`CRX_OFS_RPTR: rptr <= pwdata[`CRX_PTR_HI:`CRX_PTR_LO];
				`CRX_OFS_THR: thr <= pwdata[`CRX_PTR_HI:`CRX_PTR_LO];
				`CRX_OFS_CARE: care <= pwdata[`CRX_ID_HI:0];
				`CRX_OFS_MATCH: match <= pwdata[`CRX_ID_HI:0];
				default: ;
			endcase
		end
	end

	// ==================================================================
	// Acceptance
	// Identifier laid out as standard then extended part
	assign rx_id = {rx_msg_w0[`CRX_ID_HI:`CRX_STD_LO],
		rx_msg_w0[`CRX_EXT_HI:0]};
	assign accept_id = ((rx_id ^ match) & care) == 29'h0000_0000;
	// Stop one slot short so write never lands on read
	assign ring_full = next_pos(wptr, ring_len) == rptr;
	assign take = rx_msg_valid & enable & accept_id & ~ring_full
		& (state == crx_pkg::crx_idle);
	assign new_wptr = next_pos(wptr, ring_len);

	// Read index runs one word ahead while a word waits on the bus
	crx_msg_mem u_mem
	(
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(take),
		.wr_msg({rx_msg_w0, rx_msg_w1, rx_msg_w2, rx_msg_w3}),
		.rd_idx((state == crx_pkg::crx_send) ? word + 2'b01 : 2'b00),
		.rd_data(rd_word)
	);

	// ==================================================================
	// Ring writer
	// A message arriving while one is in flight is lost as an overrun:
	// the engine has no way to be stalled, so there is nothing to hold it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= crx_pkg::crx_idle;
			word <= 2'b00;
			mem_valid <= 1'b0;
			mem_addr <= `CRX_ZERO_RST;
			mem_wdata <= `CRX_ZERO_RST;
			rx_ev <= 17'h0_0000;
		end
		else
		begin
			rx_ev <= 17'h0_0000;
			if (rx_msg_valid && enable && !accept_id)
				rx_ev[`CRX_EV_FILTERED] <= 1'b1;
			if (rx_msg_valid && enable && accept_id
				&& (ring_full || state != crx_pkg::crx_idle))
				rx_ev[`CRX_EV_OVERRUN] <= 1'b1;
			unique case (state)
				crx_pkg::crx_idle:
				begin
					word <= 2'b00;
					if (take)
						state <= crx_pkg::crx_load;
				end
				crx_pkg::crx_load:
				begin
					// Store word sits at ring base plus slot plus word
					mem_addr <= {base, 10'h000}
						+ {12'h000, wptr, 4'h0}
						+ {28'h000_0000, word, 2'b00};
					mem_wdata <= rd_word;
					mem_valid <= 1'b1;
					state <= crx_pkg::crx_send;
				end
				crx_pkg::crx_send:
				begin
					if (mem_ready)
					begin
						mem_valid <= 1'b0;
						if (mem_error)
						begin
							// Pointers untouched for failure analysis
							rx_ev[`CRX_EV_BUSFAULT] <= 1'b1;
							state <= crx_pkg::crx_idle;
						end
						else if (word == 2'b11)
						begin
							rx_ev[`CRX_EV_RECV] <= 1'b1;
							if (new_wptr == thr)
								rx_ev[`CRX_EV_THRESH] <= 1'b1;
							if (next_pos(new_wptr, ring_len) == rptr)
								rx_ev[`CRX_EV_FILLED] <= 1'b1;
							state <= crx_pkg::crx_idle;
						end
						else
						begin
							word <= word + 2'b01;
							state <= crx_pkg::crx_load;
						end
					end
				end
				default: state <= crx_pkg::crx_idle;
			endcase
		end
	end

	// Write pointer: software sets the start, completion advances it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wptr <= 16'h0000;
		else if (state == crx_pkg::crx_send && mem_ready && !mem_error
			&& word == 2'b11)
			wptr <= new_wptr;
		else if (wr_acc && paddr == `CRX_OFS_WPTR)
			wptr <= pwdata[`CRX_PTR_HI:`CRX_PTR_LO];
	end

	// ==================================================================
	// Event registers
	// Read-clear removes only what was pending at setup, so an event landing
	// between setup and access survives to the next read
	assign rd_clear = rd_acc
		&& (paddr == `CRX_OFS_PIR || paddr == `CRX_OFS_PIMR);

	// Snapshot of pending taken with the read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			snap <= 17'h0_0000;
		else if (setup)
			snap <= pend;
	end

	// Clear, force, then new events; a set always beats a clear
	always_comb
	begin
		next_pend = pend;
		if (rd_clear)
			next_pend = next_pend & ~snap;
		if (wr_acc && paddr == `CRX_OFS_PICR)
			next_pend = next_pend & ~pwdata[`CRX_EV_HI:0];
		if (wr_acc && paddr == `CRX_OFS_PIR)
			next_pend = next_pend | pwdata[`CRX_EV_HI:0];
		next_pend = next_pend | rx_ev
			| (core_event & ~`CRX_EV_RX_OWNED);
	end

	// Pending and mask registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend <= 17'h0_0000;
			mask <= 17'h0_0000;
		end
		else
		begin
			pend <= next_pend;
			if (wr_acc && paddr == `CRX_OFS_IMR)
				mask <= pwdata[`CRX_EV_HI:0];
		end
	end

	// Module interrupt, one cycle behind pending
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(pend & mask);
	end

endmodule

// ---- verif/crx_mem_model.sv ----
// System memory model behind the ring writer's bus port.
// Assumes one outstanding word; wait_n sets latency, bad_addr faults.
`timescale 1ns/100ps

module crx_mem_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [1:0] wait_n,
	input wire logic [31:0] bad_addr,
	output logic mem_ready,
	output logic mem_error
);
	logic [1:0] cnt;
	logic [31:0] store [0:1023];

	// ==================================================================
	// Answer each word after wait_n cycles, one-cycle ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 2'h0;
			mem_ready <= 1'b0;
			mem_error <= 1'b0;
		end
		else if (mem_valid && !mem_ready && cnt == wait_n)
		begin
			cnt <= 2'h0;
			mem_ready <= 1'b1;
			mem_error <= (mem_addr == bad_addr);
		end
		else
		begin
			cnt <= (mem_valid && !mem_ready) ? cnt + 2'h1 : 2'h0;
			mem_ready <= 1'b0;
			mem_error <= 1'b0;
		end
	end

	// Faulted words are not stored
	always_ff @(posedge pclk)
	begin
		if (mem_valid && !mem_ready && cnt == wait_n && mem_addr != bad_addr)
			store[mem_addr[11:2]] <= mem_wdata;
	end
endmodule

// ---- verif/crx_ring_sva.sv ----
// Checker for the receive ring block, bound to its top module.
// Assumes zero-wait APB and word-by-word system bus writes.
`timescale 1ns/100ps

module crx_ring_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic rx_msg_valid,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic mem_ready,
	input wire logic mem_error,
	input wire logic irq
);
	// ==================================================================
	// Helper state
	logic mask_set;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Sticky: irq cannot rise before any mask bit was set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_set <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h30 && |pwdata)
			mask_set <= 1'b1;
	end

	sequence s_word_done;
		mem_valid && mem_ready && !mem_error;
	endsequence
	sequence s_fault;
		mem_valid && mem_ready && mem_error;
	endsequence

	// ==================================================================
	// Properties
	a_setup_no_err: assert property (psel && !penable |-> !pslverr)
		else $error("slave error in setup");
	a_unmapped_err: assert property (psel && penable |->
		pslverr == (paddr > 8'h34 || paddr[1:0] != 2'h0))
		else $error("slave error wrong");
	a_req_held: assert property (mem_valid && !mem_ready |=> mem_valid
		&& $stable(mem_addr) && $stable(mem_wdata))
		else $error("bus request changed");
	a_word_gap: assert property (mem_valid && mem_ready |=> !mem_valid)
		else $error("no gap after word");
	a_first_word: assert property (
		$rose(mem_valid) && mem_addr[3:2] == 2'h0
		|-> $past(rx_msg_valid, 2))
		else $error("first word timing");
	a_word_next: assert property (
		s_word_done and mem_addr[3:2] != 2'h3
		|=> ##1 mem_valid && mem_addr == $past(mem_addr, 2) + 32'h4)
		else $error("next word address");
	a_fault_stops: assert property (s_fault |=> !mem_valid [*2])
		else $error("transfer after fault");
	a_irq_masked: assert property (!mask_set |-> !irq)
		else $error("irq while masked");
endmodule

bind crx_ring crx_ring_sva i_crx_ring_sva
(
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pslverr, .rx_msg_valid, .mem_valid, .mem_addr, .mem_wdata,
	.mem_ready, .mem_error, .irq
);

// ---- verif/tb_top.sv ----
// Self-checking bench for the receive ring block.
// Assumes the memory model and checker files compile first.
`timescale 1ns/100ps

module tb_top;
	localparam logic [10:0] GOOD = 11'h123;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, mem_addr, mem_wdata, q;
	logic [31:0] w0 = 32'h0000_0000, w1 = 32'h0000_0000;
	logic [31:0] w2 = 32'h0000_0000, w3 = 32'h0000_0000;
	logic pready, pslverr, mem_valid, mem_ready, mem_error, irq, sl;
	logic rx_msg_valid = 1'b0;
	logic [16:0] core_event = 17'h0_0000;
	logic [1:0] wait_n = 2'h0;
	logic [31:0] bad_addr = 32'hFFFF_FFFC;
	int err_total = 0, n_checks = 0;

	// ==================================================================
	// Clock, instances, watchdog
	always #4 pclk = ~pclk;

	crx_ring i_crx_ring
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .rx_msg_valid, .rx_msg_w0(w0),
		.rx_msg_w1(w1), .rx_msg_w2(w2), .rx_msg_w3(w3), .core_event,
		.mem_valid, .mem_addr, .mem_wdata, .mem_ready, .mem_error, .irq
	);
	crx_mem_model i_crx_mem_model
	(
		.pclk, .presetn, .mem_valid, .mem_addr, .mem_wdata, .wait_n,
		.bad_addr, .mem_ready, .mem_error
	);

	// Far beyond the few hundred cycles the tests need
	initial
	begin
		#100000;
		err_total++;
		report_and_stop();
	end

	// ==================================================================
	// Shared tasks
	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	// One APB transfer; read data and error kept in q and sl
	task automatic xf(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [31:0] mw(input int k, input logic [10:0] id,
		input logic [7:0] n);
		case (k)
			0: return {3'h0, id, 18'h2_AAAA};
			1: return {24'h10_0000, n};
			2: return {16'h0000, n, 8'h55};
			default: return {n, 24'hC3_0F00};
		endcase
	endfunction

	// Pulse one message, then wait for its four words or give up
	task automatic send(input logic [10:0] id, input logic [7:0] n);
		int k = 0;
		w0 <= mw(0, id, n);
		w1 <= mw(1, id, n);
		w2 <= mw(2, id, n);
		w3 <= mw(3, id, n);
		rx_msg_valid <= 1'b1;
		@(posedge pclk);
		rx_msg_valid <= 1'b0;
		for (int i = 0; i < 80 && k < 4; i++)
		begin
			@(posedge pclk);
			if (mem_valid && mem_ready)
				k++;
		end
		repeat (4) @(posedge pclk);
	endtask

	task automatic stored(input int slot, input logic [7:0] n);
		for (int k = 0; k < 4; k++)
			chk("ring word", i_crx_mem_model.store[256 + slot * 4 + k],
				mw(k, GOOD, n));
	endtask

	// Write pointer, then events (the read clears them)
	task automatic ptr_ev(input logic [31:0] wp, input logic [31:0] ev);
		xf(1'b0, 8'h0C, 32'h0000_0000);
		chk("write pointer", q, wp);
		xf(1'b0, 8'h2C, 32'h0000_0000);
		chk("events", q, ev);
	endtask

	// ==================================================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] a;
		for (int i = 3; i < 14; i++)
		begin
			a = 8'(i * 4);
			xf(1'b0, a, 32'h0000_0000);
			chk("reset value", q,
				(a == 8'h18) ? 32'h1FFF_FFFF : 32'h0000_0000);
		end
		xf(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped error", {31'h0, sl}, 32'h0000_0001);
		chk("ready", {31'h0, pready}, 32'h0000_0001);
	endtask

	task automatic t_events();
		core_event <= 17'h1_8001;
		@(posedge pclk);
		core_event <= 17'h0_0000;
		@(posedge pclk);
		xf(1'b0, 8'h28, 32'h0000_0000);
		chk("event bits", q, 32'h0001_0001);
		xf(1'b1, 8'h2C, 32'h0000_0002);
		xf(1'b0, 8'h28, 32'h0000_0000);
		chk("forced bits", q, 32'h0001_0003);
		xf(1'b1, 8'h30, 32'h0000_0003);
		repeat (2) @(posedge pclk);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		xf(1'b0, 8'h20, 32'h0000_0000);
		chk("masked status", q, 32'h0000_0003);
		xf(1'b1, 8'h34, 32'h0001_0001);
		xf(1'b0, 8'h28, 32'h0000_0000);
		chk("after clear", q, 32'h0000_0002);
		xf(1'b0, 8'h24, 32'h0000_0000);
		chk("masked read", q, 32'h0000_0002);
		xf(1'b0, 8'h28, 32'h0000_0000);
		chk("cleared by masked", q, 32'h0000_0000);
		xf(1'b1, 8'h2C, 32'h0000_0010);
		repeat (2) @(posedge pclk);
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		ptr_ev(32'h0000_0000, 32'h0000_0010);
		xf(1'b0, 8'h28, 32'h0000_0000);
		chk("cleared by read", q, 32'h0000_0000);
		xf(1'b1, 8'h30, 32'h0000_0000);
	endtask

	// Ring of four slots, threshold at slot two
	task automatic t_ring();
		xf(1'b1, 8'h04, 32'h0000_0400);
		xf(1'b1, 8'h08, 32'h0000_0040);
		xf(1'b1, 8'h14, 32'h0000_0020);
		xf(1'b1, 8'h18, 32'h1FFC_0000);
		xf(1'b1, 8'h1C, {3'h0, GOOD, 18'h0_0000});
		xf(1'b1, 8'h00, 32'h0000_0001);
		send(GOOD, 8'h01);
		wait_n <= 2'h3;
		send(GOOD, 8'h02);
		wait_n <= 2'h0;
		send(11'h124, 8'h03);
		stored(0, 8'h01);
		stored(1, 8'h02);
		ptr_ev(32'h0000_0020, 32'h0000_8220);
		send(GOOD, 8'h04);
		send(GOOD, 8'h05);
		stored(2, 8'h04);
		ptr_ev(32'h0000_0030, 32'h0000_0284);
		xf(1'b1, 8'h10, 32'h0000_0010);
		send(GOOD, 8'h06);
		stored(3, 8'h06);
		ptr_ev(32'h0000_0000, 32'h0000_0280);
		xf(1'b1, 8'h10, 32'h0000_0020);
		bad_addr <= 32'h0000_0400;
		send(GOOD, 8'h07);
		ptr_ev(32'h0000_0000, 32'h0000_0008);
		// Channel off, start point moved, then a fault with abort set
		xf(1'b1, 8'h00, 32'h0000_0004);
		xf(1'b1, 8'h0C, 32'h0000_0020);
		xf(1'b0, 8'h0C, 32'h0000_0000);
		chk("set write pointer", q, 32'h0000_0020);
		xf(1'b1, 8'h00, 32'h0000_0005);
		bad_addr <= 32'h0000_0420;
		send(GOOD, 8'h08);
		ptr_ev(32'h0000_0020, 32'h0000_0008);
		xf(1'b0, 8'h00, 32'h0000_0000);
		chk("abort clears enable", q, 32'h0000_0004);
		send(GOOD, 8'h09);
		ptr_ev(32'h0000_0020, 32'h0000_0000);
	endtask

	// ==================================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_events();
		t_ring();
		report_and_stop();
	end
endmodule
